// >>> core/bbo_pkg.sv
// Constants shared by the board option logic and its parallel interface.
// Assumes a 250 MHz system clock, from which the processor and bus clocks
// are divided.
package bbo_pkg;
   localparam logic [7:0] IO_BASE_RIGHT = 8'h00;
   localparam logic [7:0] IO_BASE_LEFT = 8'h10;
   localparam logic [3:0] OFF_PORT_FIRST = 4'h4;
   localparam logic [3:0] OFF_PORT_SECOND = 4'h5;
   localparam logic [3:0] OFF_PORT_THIRD = 4'h6;
   localparam logic [3:0] OFF_PORT_CMD = 4'h7;
   localparam logic [3:0] OFF_BOOT_DONE = 4'hA;
   localparam logic [4:0] ROM_TOP_PAGE = 5'h1F;
   localparam logic [7:0] CMD_RESET = 8'h9B;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam int CMD_MODE_SET = 7;
   localparam int CMD_A_BIDIR = 6;
   localparam int CMD_A_IN = 4;
   localparam int CMD_CU_IN = 3;
   localparam int CMD_B_IN = 1;
   localparam int CMD_CL_IN = 0;
   localparam int PC_ACK = 6;
   localparam int PC_BUSY = 5;
   localparam int PC_ONLINE = 4;
   localparam int CLK_MHZ = 250;
   localparam int HALF_2M_NS = 250;
   localparam int HALF_4M_NS = 125;
   localparam logic [6:0] HALF_2M_CYC = 7'(HALF_2M_NS * CLK_MHZ / 1000);
   localparam logic [6:0] HALF_4M_CYC = 7'(HALF_4M_NS * CLK_MHZ / 1000);
endpackage

// >>> core/bbo_ppi_if.sv
// Register access path from the board decoder to the parallel interface.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface bbo_ppi_if;
   logic sel;
   logic [1:0] idx;
   logic rd;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dec (output sel, idx, rd, wr, wdata, input rdata);
   modport ppi (input sel, idx, rd, wr, wdata, output rdata);
endinterface
`default_nettype wire

// >>> core/bbo_ppi.sv
// Three-port parallel interface with command register and printer status.
// Assumes the decoder qualifies sel with an I/O cycle at the right port.
`timescale 1ns/1ns
`default_nettype none
module bbo_ppi (
   // Clock and control
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Register access
   bbo_ppi_if.ppi rif,
   // Port pins
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic pa_oe,
   input wire logic [7:0] pb_in,
   output logic [7:0] pb_out,
   output logic pb_oe,
   input wire logic [7:0] pc_in,
   output logic [7:0] pc_out,
   output logic [7:0] pc_oe
);
   import bbo_pkg::*;
   logic [7:0] pa_q, pb_q, pc_q, cmd_q;
   logic pa_drive_q;
   logic wr_a, wr_b, wr_c, wr_cmd;

   assign wr_a = ce && rif.sel && rif.wr && rif.idx == OFF_PORT_FIRST[1:0];
   assign wr_b = ce && rif.sel && rif.wr && rif.idx == OFF_PORT_SECOND[1:0];
   assign wr_c = ce && rif.sel && rif.wr && rif.idx == OFF_PORT_THIRD[1:0];
   assign wr_cmd = ce && rif.sel && rif.wr && rif.idx == OFF_PORT_CMD[1:0];

   // Mode set clears output latches; otherwise single bit set/reset of C
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cmd_q <= CMD_RESET;
      end else if (wr_cmd && rif.wdata[CMD_MODE_SET]) begin
         cmd_q <= rif.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pa_q <= PORT_RESET;
         pb_q <= PORT_RESET;
      end else if (wr_cmd && rif.wdata[CMD_MODE_SET]) begin
         pa_q <= PORT_RESET;
         pb_q <= PORT_RESET;
      end else begin
         if (wr_a) begin
            pa_q <= rif.wdata;
         end
         if (wr_b) begin
            pb_q <= rif.wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pc_q <= PORT_RESET;
      end else if (wr_cmd && rif.wdata[CMD_MODE_SET]) begin
         pc_q <= PORT_RESET;
      end else if (wr_cmd) begin
         pc_q[rif.wdata[3:1]] <= rif.wdata[0];
      end else if (wr_c) begin
         pc_q <= rif.wdata;
      end
   end

   // Bidirectional A drives after a write and releases after a read
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pa_drive_q <= 1'b0;
      end else if (wr_cmd && rif.wdata[CMD_MODE_SET]) begin
         // New mode starts with A released, not a stale drive
         pa_drive_q <= 1'b0;
      end else if (wr_a) begin
         pa_drive_q <= 1'b1;
      end else if (ce && rif.sel && rif.rd
                   && rif.idx == OFF_PORT_FIRST[1:0]) begin
         pa_drive_q <= 1'b0;
      end
   end

   assign pa_out = pa_q;
   assign pb_out = pb_q;
   assign pc_out = pc_q;
   assign pa_oe = cmd_q[CMD_A_BIDIR] ? pa_drive_q : !cmd_q[CMD_A_IN];
   assign pb_oe = !cmd_q[CMD_B_IN];
   assign pc_oe = {{4{!cmd_q[CMD_CU_IN]}}, {4{!cmd_q[CMD_CL_IN]}}};

   always_comb begin
      rif.rdata = 8'h00;
      case (rif.idx)
         OFF_PORT_FIRST[1:0]: rif.rdata = pa_oe ? pa_q : pa_in;
         OFF_PORT_SECOND[1:0]: rif.rdata = pb_oe ? pb_q : pb_in;
         OFF_PORT_THIRD[1:0]: rif.rdata = (pc_q & pc_oe) | (pc_in & ~pc_oe);
         default: rif.rdata = 8'h00;
      endcase
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_printer_status: assert property (
      (rif.idx == OFF_PORT_THIRD[1:0] && cmd_q[CMD_CU_IN])
      |-> rif.rdata[PC_ACK:PC_ONLINE] == pc_in[PC_ACK:PC_ONLINE])
      else $error("printer status not seen on third port");
   chk_mode_clear: assert property (
      wr_cmd && rif.wdata[CMD_MODE_SET]
      |=> pa_q == PORT_RESET && pb_q == PORT_RESET && cmd_q == $past(rif.wdata))
      else $error("mode set did not load command and clear ports");
   chk_bit_set: assert property (
      wr_cmd && !rif.wdata[CMD_MODE_SET]
      |=> pc_q[$past(rif.wdata[3:1])] == $past(rif.wdata[0]))
      else $error("third port bit set or reset failed");
   cov_a_bidir: cover property (cmd_q[CMD_A_BIDIR] && pa_drive_q ##1 !pa_drive_q);
endmodule
`default_nettype wire

// >>> core/bbo_top.sv
// Board option logic: I/O decode, fetch wait, clocks, boot ROM, write strobe.
// Assumes bus qualifiers are synchronous to clk and jumpers are static.
`timescale 1ns/1ns
`default_nettype none
module bbo_top (
   // Clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // Jumper options
   input wire logic fetch_wait_option,
   input wire logic cpu_speed_option,
   input wire logic boot_rom_kill_option,
   input wire logic io_base_option,
   input wire logic mem_write_strobe_option,
   input wire logic power_on_jump_kill_option,
   // Processor side bus
   input wire logic [15:0] addr,
   input wire logic io_cycle,
   input wire logic instruction_fetch_cycle,
   input wire logic mem_read,
   input wire logic mem_write,
   input wire logic rd_stb,
   input wire logic wr_stb,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic rdata_valid,
   // Backplane and memory outputs
   output logic cpu_clk,
   output logic bus_clk,
   output logic wait_req,
   output logic rom_sel,
   output logic mem_write_strobe_out,
   output logic mem_write_strobe_oe,
   // Parallel pins
   input wire logic [7:0] pa_in,
   output logic [7:0] pa_out,
   output logic pa_oe,
   input wire logic [7:0] pb_in,
   output logic [7:0] pb_out,
   output logic pb_oe,
   input wire logic [7:0] pc_in,
   output logic [7:0] pc_out,
   output logic [7:0] pc_oe,
   // Printer
   input wire logic printer_ack_in,
   input wire logic printer_busy_in,
   input wire logic printer_online_in,
   output logic [7:0] printer_data,
   output logic printer_strobe
);
   import bbo_pkg::*;

   function automatic logic io_match(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input logic [3:0] lo,
                                     input logic [3:0] hi);
      io_match = a[7:4] == base[7:4] && a[3:0] >= lo && a[3:0] <= hi;
   endfunction

   bbo_ppi_if rif ();
   logic [7:0] io_base;
   logic ppi_hit, boot_hit;
   logic [7:0] rdata_q;
   logic rdata_valid_q;
   logic boot_low_q;
   logic fetch_seen_q;
   logic [6:0] cpu_cnt_q, bus_cnt_q, cpu_half;
   logic cpu_clk_q, bus_clk_q;
   logic [7:0] pc_merged;

   assign io_base = io_base_option ? IO_BASE_LEFT : IO_BASE_RIGHT;
   assign ppi_hit = io_cycle
      && io_match(addr[7:0], io_base, OFF_PORT_FIRST, OFF_PORT_CMD);
   assign boot_hit = io_cycle
      && io_match(addr[7:0], io_base, OFF_BOOT_DONE, OFF_BOOT_DONE);

   assign rif.sel = ppi_hit;
   assign rif.idx = addr[1:0];
   assign rif.rd = rd_stb;
   assign rif.wr = wr_stb;
   assign rif.wdata = wdata;

   // Printer status lines feed third-port bits 6..4
   assign pc_merged = {pc_in[7], printer_ack_in, printer_busy_in,
                       printer_online_in, pc_in[3:0]};

   bbo_ppi u_ppi (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .rif(rif),
      .pa_in(pa_in),
      .pa_out(pa_out),
      .pa_oe(pa_oe),
      .pb_in(pb_in),
      .pb_out(pb_out),
      .pb_oe(pb_oe),
      .pc_in(pc_merged),
      .pc_out(pc_out),
      .pc_oe(pc_oe)
   );

   assign printer_data = pa_out;
   assign printer_strobe = pb_out[0];

   // Read data registered one clock after the strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         rdata_valid_q <= 1'b0;
      end else if (ce) begin
         rdata_valid_q <= ppi_hit && rd_stb;
         if (ppi_hit && rd_stb) begin
            rdata_q <= rif.rdata;
         end
      end
   end
   assign rdata = rdata_q;
   assign rdata_valid = rdata_valid_q;

   // Boot ROM shadows every 2K page until the boot port is read
   always_ff @(posedge clk) begin
      if (!nrst) begin
         boot_low_q <= 1'b1;
      end else if (ce && (power_on_jump_kill_option
                          || (boot_hit && rd_stb))) begin
         boot_low_q <= 1'b0;
      end
   end
   assign rom_sel = mem_read && !boot_rom_kill_option
      && (boot_low_q || addr[15:11] == ROM_TOP_PAGE);

   // One wait request on the first clock of each fetch
   always_ff @(posedge clk) begin
      if (!nrst) begin
         fetch_seen_q <= 1'b0;
      end else if (ce) begin
         fetch_seen_q <= instruction_fetch_cycle;
      end
   end
   assign wait_req = fetch_wait_option && instruction_fetch_cycle
      && !fetch_seen_q;

   // Processor clock divider, 2 or 4 MHz
   assign cpu_half = cpu_speed_option ? HALF_4M_CYC : HALF_2M_CYC;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cpu_cnt_q <= 7'h00;
         cpu_clk_q <= 1'b0;
      end else if (ce) begin
         if (cpu_cnt_q >= cpu_half - 7'h01) begin
            cpu_cnt_q <= 7'h00;
            cpu_clk_q <= !cpu_clk_q;
         end else begin
            cpu_cnt_q <= cpu_cnt_q + 7'h01;
         end
      end
   end

   // Backplane clock fixed at 2 MHz
   always_ff @(posedge clk) begin
      if (!nrst) begin
         bus_cnt_q <= 7'h00;
         bus_clk_q <= 1'b0;
      end else if (ce) begin
         if (bus_cnt_q == HALF_2M_CYC - 7'h01) begin
            bus_cnt_q <= 7'h00;
            bus_clk_q <= !bus_clk_q;
         end else begin
            bus_cnt_q <= bus_cnt_q + 7'h01;
         end
      end
   end
   assign cpu_clk = cpu_clk_q;
   assign bus_clk = bus_clk_q;

   assign mem_write_strobe_oe = mem_write_strobe_option;
   assign mem_write_strobe_out = mem_write && mem_write_strobe_option;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   chk_port_decode: assert property (
      io_cycle && addr[7:0] == (io_base | 8'(OFF_PORT_THIRD))
      |-> rif.sel && rif.idx == OFF_PORT_THIRD[1:0])
      else $error("third data port not decoded");
   chk_io_base: assert property (
      rif.sel |-> addr[7:4] == (io_base_option ? 4'h1 : 4'h0))
      else $error("parallel port selected outside chosen base");
   chk_decode_span: assert property (
      io_cycle && addr[7:4] == io_base[7:4] && addr[3:2] != 2'h1
      |-> !rif.sel)
      else $error("parallel port selected outside its four ports");
   chk_wait_one: assert property (
      ce && fetch_wait_option && $rose(instruction_fetch_cycle)
      ##1 (ce && instruction_fetch_cycle) |-> !wait_req)
      else $error("fetch wait lasted more than one clock");
   chk_wait_fetch: assert property (
      wait_req |-> instruction_fetch_cycle && fetch_wait_option)
      else $error("wait inserted outside a fetch");
   chk_bus_clk: assert property (
      ce && bus_cnt_q == HALF_2M_CYC - 7'h01 |=> $changed(bus_clk))
      else $error("bus clock did not toggle at half period");
   chk_cpu_fast: assert property (
      cpu_speed_option && ce && $changed(cpu_clk) ##1 ce[*8]
      |-> $stable(cpu_clk))
      else $error("processor clock toggled too early");
   chk_rom_kill: assert property (
      boot_rom_kill_option |-> !rom_sel)
      else $error("boot ROM read while killed");
   chk_rom_high: assert property (
      ce && boot_hit && rd_stb ##1 mem_read && !boot_rom_kill_option
      && addr[15:11] != ROM_TOP_PAGE |-> !rom_sel)
      else $error("boot ROM still shadowed after boot port read");
   chk_mwr_strobe: assert property (
      mem_write_strobe_out |-> mem_write_strobe_option && mem_write)
      else $error("write strobe driven without option");
   cov_fetch_wait: cover property (wait_req ##1 !wait_req);
   cov_boot_exit: cover property (boot_low_q ##1 !boot_low_q);
   cov_ppi_read: cover property (ppi_hit && rd_stb ##1 rdata_valid);
endmodule
`default_nettype wire

// >>> test/bbo_printer_model.sv
// Far side of the parallel connector: printer status and pin levels.
// Assumes the bench sets pat and stat; released lines show pat, or ~pat on the second port.
`timescale 1ns/1ns
`default_nettype none
module bbo_printer_model (
   // Design side
   input wire logic [7:0] pa_out,
   input wire logic pa_oe,
   input wire logic [7:0] pb_out,
   input wire logic pb_oe,
   input wire logic [7:0] pc_out,
   input wire logic [7:0] pc_oe,
   // Bench control
   input wire logic [7:0] pat,
   input wire logic [2:0] stat,
   // Pins and printer status
   output logic [7:0] pa_in,
   output logic [7:0] pb_in,
   output logic [7:0] pc_in,
   output logic printer_ack_in,
   output logic printer_busy_in,
   output logic printer_online_in
);
   // Undriven lines carry the far side's own pattern
   assign pa_in = pa_oe ? pa_out : pat;
   assign pb_in = pb_oe ? pb_out : ~pat;
   assign pc_in = (pc_oe & pc_out) | (~pc_oe & pat);
   assign {printer_ack_in, printer_busy_in, printer_online_in} = stat;
endmodule
`default_nettype wire

// >>> test/tb_board_bus_option_logic.sv
// Self-checking bench for the board option logic.
// Assumes bbo_top and the printer model; jumpers change only in reset.
`timescale 1ns/1ns
`default_nettype none
module tb_board_bus_option_logic;
   import bbo_pkg::*;
   logic clk = 0, nrst = 0, ce = 1, io_cycle = 0, mem_read = 0;
   logic fetch_wait_option = 0, cpu_speed_option = 0;
   logic boot_rom_kill_option = 0, io_base_option = 0;
   logic mem_write_strobe_option = 0, power_on_jump_kill_option = 0;
   logic instruction_fetch_cycle = 0, mem_write = 0, rd_stb = 0, wr_stb = 0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00, pat = 8'h00, rdata, pa_in, pb_in, pc_in;
   logic [7:0] pa_out, pb_out, pc_out, pc_oe, printer_data, r, b;
   logic [2:0] stat = 3'h0;
   logic rdata_valid, cpu_clk, bus_clk, wait_req, rom_sel, pa_oe, pb_oe;
   logic mem_write_strobe_out, mem_write_strobe_oe, printer_strobe;
   logic printer_ack_in, printer_busy_in, printer_online_in;
   integer seed = 21593;
   int n_errors = 0, check_count = 0;

   bbo_top uut (.clk, .nrst, .ce, .fetch_wait_option, .cpu_speed_option,
      .boot_rom_kill_option, .io_base_option, .mem_write_strobe_option,
      .power_on_jump_kill_option, .addr, .io_cycle, .instruction_fetch_cycle,
      .mem_read, .mem_write, .rd_stb, .wr_stb, .wdata, .rdata, .rdata_valid,
      .cpu_clk, .bus_clk, .wait_req, .rom_sel, .mem_write_strobe_out,
      .mem_write_strobe_oe, .pa_in, .pa_out, .pa_oe, .pb_in, .pb_out, .pb_oe,
      .pc_in, .pc_out, .pc_oe, .printer_ack_in, .printer_busy_in,
      .printer_online_in, .printer_data, .printer_strobe);
   bbo_printer_model far (.pa_out, .pa_oe, .pb_out, .pb_oe, .pc_out, .pc_oe,
      .pat, .stat, .pa_in, .pb_in, .pc_in, .printer_ack_in, .printer_busy_in,
      .printer_online_in);

   always #2 clk = ~clk;

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] exp_rd(input int p, input logic [7:0] v,
                                         input logic [2:0] s);
      case (p)
         4: exp_rd = v;
         5: exp_rd = ~v;
         6: exp_rd = {v[7], s, v[3:0]};
         default: exp_rd = 8'h00;
      endcase
   endfunction

   task automatic setup(input logic [5:0] o);
      @(posedge clk);
      {fetch_wait_option, cpu_speed_option, boot_rom_kill_option,
         io_base_option, mem_write_strobe_option,
         power_on_jump_kill_option} <= o;
      nrst <= 0;
      repeat (8) @(posedge clk);
      nrst <= 1;
      @(negedge clk);
   endtask

   // One I/O access; upper address byte is random noise
   task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= {8'($random(seed)), a};
      io_cycle <= 1;
      rd_stb <= !w;
      wr_stb <= w;
      wdata <= d;
      @(posedge clk);
      io_cycle <= 0;
      rd_stb <= 0;
      wr_stb <= 0;
      @(negedge clk);
   endtask

   task automatic rom(input logic [15:0] a, input logic e);
      @(posedge clk);
      addr <= a;
      mem_read <= 1;
      @(negedge clk);
      chk("rom_sel", 8'(e), 8'(rom_sel));
      chk("wait_req on read", 8'h00, 8'(wait_req));
      @(posedge clk) mem_read <= 0;
   endtask

   task automatic half(input logic bc, input logic [6:0] e);
      logic v;
      int n;
      repeat (2) begin
         n = 0;
         v = bc ? bus_clk : cpu_clk;
         while ((bc ? bus_clk : cpu_clk) === v && n < 300) begin
            @(negedge clk);
            n++;
         end
      end
      chk(bc ? "bus_clk half" : "cpu_clk half", {1'b0, e}, 8'(n));
   endtask

   initial begin
      for (int k = 0; k < 2; k++) begin
         setup({k[0], k[0], 1'b0, k[0], k[0], 1'b0});
         b = k[0] ? IO_BASE_LEFT : IO_BASE_RIGHT;
         chk("oe after reset", 8'h00, 8'({pa_oe, pb_oe}) | pc_oe);
         rom(16'h0000, 1);
         half(0, k[0] ? HALF_4M_CYC : HALF_2M_CYC);
         half(1, HALF_2M_CYC);
         @(posedge clk) mem_write <= 1;
         @(negedge clk);
         chk("strobe", 8'(k[0]), 8'(mem_write_strobe_out));
         chk("strobe oe", 8'(k[0]), 8'(mem_write_strobe_oe));
         mem_write <= 0;
         @(posedge clk) instruction_fetch_cycle <= 1;
         @(negedge clk);
         chk("wait first", 8'(k[0]), 8'(wait_req));
         @(negedge clk);
         chk("wait second", 8'h00, 8'(wait_req));
         @(posedge clk) instruction_fetch_cycle <= 0;
         for (int p = 3; p < 9; p++) begin
            pat <= 8'($random(seed));
            stat <= 3'($random(seed));
            io(0, b + 8'(p), 8'h00);
            chk("read valid", 8'(p > 3 && p < 8), 8'(rdata_valid));
            if (p > 3 && p < 8) begin
               chk("read data", exp_rd(p, pat, stat), rdata);
            end
            io(0, (b ^ 8'h10) + 8'(p), 8'h00);
            chk("other base", 8'h00, 8'(rdata_valid));
         end
         io(0, b + 8'h0A, 8'h00);
         rom(16'h0000, 0);
         rom({5'h1F, 11'($random(seed))}, 1);
         r = 8'($random(seed));
         io(1, b + 8'h07, 8'h80);
         io(1, b + 8'h04, r);
         chk("pa_out", r, pa_out);
         chk("printer_data", r, printer_data);
         chk("pa_oe", 8'h01, 8'(pa_oe));
         io(1, b + 8'h05, ~r);
         chk("printer_strobe", {7'h00, ~r[0]}, 8'(printer_strobe));
         chk("pb_out", ~r, pb_out);
         chk("pb_oe", 8'h01, 8'(pb_oe));
         io(1, b + 8'h07, 8'h0D);
         chk("pc bit6", 8'h01, 8'(pc_out[6]));
         // Write with enable low must not land
         ce <= 0;
         io(1, b + 8'h04, ~r);
         ce <= 1;
         chk("pa frozen", r, pa_out);
         // Bidirectional A: drive after write, release after read
         io(1, b + 8'h07, 8'hC0);
         chk("pa_oe bidir idle", 8'h00, 8'(pa_oe));
         io(1, b + 8'h04, r);
         chk("pa_oe bidir write", 8'h01, 8'(pa_oe));
         io(0, b + 8'h04, 8'h00);
         chk("bidir read", r, rdata);
         chk("pa_oe bidir read", 8'h00, 8'(pa_oe));
      end
      setup(6'b001000);
      rom(16'h0000, 0);
      rom(16'hF800, 0);
      setup(6'b000001);
      rom(16'h0000, 0);
      rom(16'hFFFF, 1);
      // Advised setting: fast clock, no fetch wait
      setup(6'b010000);
      half(0, HALF_4M_CYC);
      @(posedge clk) instruction_fetch_cycle <= 1;
      @(negedge clk);
      chk("wait none", 8'h00, 8'(wait_req));
      @(posedge clk) instruction_fetch_cycle <= 0;
      stop_test();
   end

   // Whole run is under a thousand cycles
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
endmodule
`default_nettype wire
